// ---- hw/scp_top.sv ----
// How it works
// (RULE1) At boot the block masters the two-wire bus and reads the memory.
// (RULE2) Two-wire bytes move eight bits at a time at 50 Kbps.
// (RULE3) Start pulls SDA low while SCL is high; bus then busy.
// (RULE4) SDA changes only while SCL is low, except start and stop.
// (RULE5) Idle bus leaves both lines high.
// (RULE6) First byte after start carries the memory address in seven bits.
// (RULE7) Eighth bit of first byte is write or read direction.
// (RULE8) Every byte gets an ack pulse; the receiver pulls SDA low.
// (RULE9) A missing ack from the memory abandons the transfer with a stop.
// (RULE10) After a withheld ack the memory releases SDA for the stop.
// (RULE11) Bytes after the address are data, MSB first, each acked; the code withholds the ack on the last boot read byte.
// (RULE12) Stop raises SDA while SCL is high; bus then free.
// (RULE13) Serial port: host is master, same framing, no ack bits.
// (RULE14) Strobe is debounced; a pin turns debounce off.
// (RULE15) A strapped 3-bit id selects which of eight devices answers.
// (RULE16) Address, command and write data shift in; read data shifts out.
// (RULE17) Host sends start, address, command, then data.
// (RULE18) Start: input high at strobe rise, low at next fall.
// (RULE19) Abort: input low at strobe rise, high at next fall.
// (RULE20) Abort cancels a write anytime, a read only before its command.
// (RULE21) A write completes after two more strobes with input high.
// (RULE22) Every register is readable and writable over the serial port.
// (RULE23) Index location holds the register address; data location the value.
// (RULE24) Paired flag: 16-bit write stores low byte, high byte at next.
// (RULE25) Increment flag steps the index after each data access.
// (RULE26) Fields shift MSB first; read data one bit per strobe.
// (RULE27) Boot clock is divided from the core clock to the rate.
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_top
  import scp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Boot two-wire bus, open drain.
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // Synchronous serial port.
  input wire logic serial_strobe_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  // Straps.
  input wire logic [2:0] dev_id_strap,
  input wire logic debounce_off,
  // Status.
  output logic boot_done,
  output logic boot_error,
  output logic serial_busy
);
  // ==========================================
  // Pin conditioning.
  logic st_rise;
  logic st_fall;
  logic din_level;
  logic [3:0] ctl_level;

  scp_link_in u_link (
    .clk(clk),
    .rst_n(rst_n),
    .pin_raw({dev_id_strap, debounce_off, serial_in_line, serial_strobe_n}),
    .strobe_rise(st_rise),
    .strobe_fall(st_fall),
    .data_level(din_level),
    .ctl_level(ctl_level)
  );

  // Identifier is caught a few cycles after reset release.
  logic [2:0] dev_id_reg;
  logic [1:0] id_wait_reg;
  logic id_ok_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_id_reg <= 3'h0;
      id_wait_reg <= 2'h0;
      id_ok_reg <= 1'b0;
    end else if (!id_ok_reg) begin
      id_wait_reg <= id_wait_reg + 2'h1;
      if (id_wait_reg == `SCP_ID_WAIT) begin
        dev_id_reg <= ctl_level[3:1]; // [RULE15]
        id_ok_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // Boot sequencer driving the byte engine.
  scp_boot_t boot_st_reg;
  scp_boot_t boot_next;
  scp_op_t boot_op;
  logic [7:0] boot_tx;
  logic boot_valid_reg;
  logic boot_wait_reg;
  logic [3:0] boot_ptr_reg;
  logic boot_err_reg;
  logic boot_done_reg;
  logic line_low_reg;
  logic eng_busy;
  logic eng_done;
  logic eng_ack;
  logic [7:0] eng_rx;

  // Operation and byte chosen per state.
  wire boot_start = boot_st_reg == B_ST1 || boot_st_reg == B_ST2;
  wire boot_addr = boot_st_reg == B_DEVW || boot_st_reg == B_DEVR;
  wire boot_wbyte = boot_addr || boot_st_reg == B_WORD;
  wire boot_last = boot_ptr_reg == `SCP_REG_LAST;
  wire boot_issue = boot_op != OP_IDLE && !boot_wait_reg && !eng_busy;
  wire boot_nak = eng_done && !eng_ack && boot_wbyte;
  wire boot_wr = eng_done && boot_st_reg == B_READ;
  wire dir_bit = boot_st_reg == B_DEVR ? `SCP_DIR_RD : `SCP_DIR_WR;
  assign boot_op = boot_start ? OP_START : boot_wbyte ? OP_WRITE :
                   boot_st_reg == B_READ ? OP_READ :
                   boot_st_reg == B_STOP ? OP_STOP : OP_IDLE;
  // Address in the top seven bits, direction in the eighth.
  assign boot_tx = boot_addr ? {`SCP_EE_ADDR, dir_bit} : `SCP_BOOT_WORD; // [RULE6] [RULE7]

  // Next boot state: address write, word, repeated start, read all.
  always_comb begin
    boot_next = boot_st_reg;
    unique case (boot_st_reg)
      B_INIT: boot_next = B_ST1; // [RULE1]
      B_ST1: if (eng_done) boot_next = B_DEVW;
      B_DEVW: if (eng_done) boot_next = eng_ack ? B_WORD : B_STOP; // [RULE9]
      B_WORD: if (eng_done) boot_next = eng_ack ? B_ST2 : B_STOP; // [RULE9]
      B_ST2: if (eng_done) boot_next = B_DEVR;
      B_DEVR: if (eng_done) boot_next = eng_ack ? B_READ : B_STOP; // [RULE9]
      B_READ: if (eng_done && boot_last) boot_next = B_STOP; // [RULE11]
      B_STOP: if (eng_done) boot_next = B_DONE; // [RULE12]
      B_DONE: boot_next = B_DONE;
      default: boot_next = B_INIT;
    endcase
  end

  // Boot state, request pulse and progress.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_st_reg <= B_INIT;
      boot_valid_reg <= 1'b0;
      boot_wait_reg <= 1'b0;
      boot_ptr_reg <= 4'h0;
      boot_err_reg <= 1'b0;
      boot_done_reg <= 1'b0;
      line_low_reg <= 1'b0;
    end else begin
      boot_st_reg <= boot_next;
      boot_valid_reg <= boot_issue;
      boot_wait_reg <= boot_issue || (boot_wait_reg && !eng_done);
      if (boot_wr) boot_ptr_reg <= boot_ptr_reg + 4'h1;
      if (boot_nak) boot_err_reg <= 1'b1;
      boot_done_reg <= boot_next == B_DONE;
    end
  end

  // The last read byte is not acked, so the memory lets SDA go.
  scp_twi_byte u_twi (
    .clk(clk),
    .rst_n(rst_n),
    .op_valid(boot_valid_reg),
    .op(boot_op),
    .tx_byte(boot_tx),
    .tx_nack(boot_last), // [RULE10]
    .busy(eng_busy),
    .done(eng_done),
    .ack_seen(eng_ack),
    .rx_byte(eng_rx),
    .sda_in(sda_in),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // ==========================================
  // Serial slave port.
  scp_ser_t ser_st_reg;
  scp_ser_t ser_next;
  logic [3:0] bit_cnt_reg;
  logic [6:0] hdr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] out_sh_reg;
  logic [15:0] idx_reg;
  logic rise_bit_reg;
  logic out_reg;
  logic busy_reg;
  logic [7:0] cfg_reg [`SCP_REG_DEPTH];

  // Strobe patterns; a plain bit holds its level across the strobe.
  wire start_ev = st_fall && rise_bit_reg && !din_level; // [RULE18]
  wire abort_ev = st_fall && !rise_bit_reg && din_level; // [RULE19]
  wire bit_ev = st_fall && rise_bit_reg == din_level; // [RULE13]
  wire [6:0] hdr_new = {hdr_reg[5:0], din_level};
  wire id_hit = hdr_new[6:4] == dev_id_reg;
  wire cmd_rd = hdr_new[0] == `SCP_DIR_RD;
  wire [2:0] loc_new = hdr_new[3:1];
  wire [2:0] loc_reg = hdr_reg[3:1];
  wire hdr_end = bit_ev && ser_st_reg == S_HDR && bit_cnt_reg == `SCP_HDR_LAST;
  wire rd_load = hdr_end && id_hit && cmd_rd;
  wire commit_wr = bit_ev && ser_st_reg == S_TAIL && din_level && bit_cnt_reg[0];
  wire data_wr = commit_wr && loc_reg == `SCP_LOC_DATA;
  wire data_rd = rd_load && loc_new == `SCP_LOC_DATA;
  wire boot_busy = boot_st_reg != B_DONE;

  // Index decode: register address, pairing and auto-step.
  wire [3:0] cur_addr = idx_reg[`SCP_IDX_AMSB:0];
  wire [3:0] nxt_addr = cur_addr + 4'h1;
  wire idx_pair = idx_reg[`SCP_IDX_PAIR];
  wire idx_inc = idx_reg[`SCP_IDX_INC];
  wire [11:0] idx_stepped = idx_reg[11:0] + (idx_pair ? `SCP_STEP_TWO : `SCP_STEP_ONE);
  wire [7:0] wdata_hi = wdata_reg[15:8];
  wire [15:0] rd_word = loc_new == `SCP_LOC_INDEX ? idx_reg :
                        {cfg_reg[nxt_addr], cfg_reg[cur_addr]}; // [RULE22] [RULE23]

  // Next serial state; an abort is ignored once a read command is in.
  always_comb begin
    ser_next = ser_st_reg;
    if (start_ev) begin
      ser_next = S_HDR;
    end else if (abort_ev && ser_st_reg != S_RDATA) begin
      ser_next = S_IDLE; // [RULE20]
    end else if (bit_ev) begin
      unique case (ser_st_reg)
        S_HDR: if (hdr_end) ser_next = !id_hit ? S_SKIP : cmd_rd ? S_RDATA : S_WDATA; // [RULE15] [RULE17]
        S_WDATA: if (bit_cnt_reg == `SCP_DATA_LAST) ser_next = S_TAIL;
        S_TAIL: if (!din_level || bit_cnt_reg[0]) ser_next = S_IDLE; // [RULE21]
        S_RDATA: if (bit_cnt_reg == `SCP_DATA_LAST) ser_next = S_IDLE;
        S_IDLE, S_SKIP: ser_next = ser_st_reg;
        default: ser_next = S_IDLE;
      endcase
    end
  end

  // Serial state, bit counter and input shifters.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_st_reg <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      hdr_reg <= 7'h00;
      wdata_reg <= 16'h0000;
      rise_bit_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      ser_st_reg <= ser_next;
      busy_reg <= ser_next != S_IDLE;
      if (st_rise) rise_bit_reg <= din_level;
      if (start_ev || ser_next != ser_st_reg) begin
        bit_cnt_reg <= 4'h0;
      end else if (bit_ev) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (bit_ev && ser_st_reg == S_HDR) hdr_reg <= hdr_new; // [RULE16] [RULE26]
      if (bit_ev && ser_st_reg == S_WDATA) wdata_reg <= {wdata_reg[14:0], din_level}; // [RULE16]
    end
  end

  // Read data leaves MSB first, one bit per strobe fall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_reg <= 16'h0000;
      out_reg <= 1'b1;
    end else if (rd_load) begin
      out_sh_reg <= rd_word;
      out_reg <= rd_word[15]; // [RULE26]
    end else if (bit_ev && ser_st_reg == S_RDATA) begin
      out_sh_reg <= {out_sh_reg[14:0], 1'b0};
      out_reg <= out_sh_reg[14]; // [RULE16]
    end
  end

  // Index location write and auto-step after data accesses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= `SCP_IDX_RST;
    end else if (commit_wr && loc_reg == `SCP_LOC_INDEX) begin
      idx_reg <= wdata_reg; // [RULE23]
    end else if ((data_wr || data_rd) && idx_inc) begin
      idx_reg <= {idx_reg[15:12], idx_stepped}; // [RULE25]
    end
  end

  // Register file: boot loads first, serial writes after boot.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SCP_REG_DEPTH; i++) begin
        cfg_reg[i] <= `SCP_CFG_RST;
      end
    end else if (boot_wr) begin
      cfg_reg[boot_ptr_reg] <= eng_rx; // [RULE1]
    end else if (data_wr && !boot_busy) begin
      cfg_reg[cur_addr] <= wdata_reg[7:0]; // [RULE22]
      if (idx_pair) cfg_reg[nxt_addr] <= wdata_hi; // [RULE24]
    end
  end

  assign scl_out = line_low_reg;
  assign sda_out = line_low_reg;
  assign serial_out_line = out_reg;
  assign boot_done = boot_done_reg;
  assign boot_error = boot_err_reg;
  assign serial_busy = busy_reg;

  // ==========================================
  // Assertions.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_IDLE_HIGH: assert property (boot_done |-> !scl_oe && !sda_oe) // [RULE5]
    else $error("boot bus not released after boot");
  AST_SDA_HOLD: assert property ((!scl_oe && !$past(scl_oe) && boot_wbyte) |-> $stable(sda_oe)) // [RULE4]
    else $error("SDA moved while SCL high");
  AST_START_EDGE: assert property (($rose(sda_oe) && !scl_oe) |-> boot_start) // [RULE3]
    else $error("SDA fell with SCL high outside start");
  AST_STOP_EDGE: assert property (($fell(sda_oe) && !scl_oe) |-> boot_st_reg == B_STOP) // [RULE12]
    else $error("SDA rose with SCL high outside stop");
  AST_SCL_LOW_MIN: assert property ($rose(scl_oe) |=> scl_oe [*8]) // [RULE27]
    else $error("SCL low period too short");
  AST_NACK_ABANDON: assert property (boot_nak |=> boot_st_reg == B_STOP && boot_error) // [RULE9]
    else $error("missing ack did not lead to stop");
  AST_ADDR_BYTE: assert property ((boot_valid_reg && boot_addr) |-> boot_tx[7:1] == `SCP_EE_ADDR) // [RULE6]
    else $error("wrong memory address");
  AST_DIR_BIT: assert property ((boot_valid_reg && boot_addr) |-> boot_tx[0] == (boot_st_reg == B_DEVR)) // [RULE7]
    else $error("wrong direction bit");
  AST_ID_FILTER: assert property ((hdr_end && !id_hit) |=> ser_st_reg == S_SKIP) // [RULE15]
    else $error("foreign id not ignored");
  AST_START_SYNC: assert property (start_ev |=> ser_st_reg == S_HDR && bit_cnt_reg == 4'h0) // [RULE18]
    else $error("start not taken");
  AST_WRITE_ABORT: assert property ((abort_ev && ser_st_reg inside {S_WDATA, S_TAIL}) |=> ser_st_reg == S_IDLE) // [RULE20]
    else $error("abort did not cancel write");
  AST_READ_HOLD: assert property ((abort_ev && ser_st_reg == S_RDATA) |=> ser_st_reg == S_RDATA) // [RULE20]
    else $error("abort cut a read");
  AST_INDEX_LOAD: assert property ((commit_wr && loc_reg == `SCP_LOC_INDEX) |=> idx_reg == $past(wdata_reg)) // [RULE21]
    else $error("index write lost");
  AST_PAIR_WRITE: assert property ((data_wr && idx_pair && !boot_busy) |=> cfg_reg[$past(nxt_addr)] == $past(wdata_hi)) // [RULE24]
    else $error("paired high byte lost");

  COV_BOOT_DONE: cover property (boot_st_reg == B_STOP ##1 boot_st_reg == B_DONE);
  COV_BOOT_NAK: cover property (boot_nak);
  COV_SER_WRITE: cover property (data_wr);
  COV_SER_READ: cover property (data_rd);
endmodule

// ---- hw/scp_regs.svh ----
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// ==========================================
// Timing of the boot bus and the serial port.
`define SCP_CLK_NS 40
`define SCP_BIT_NS 20000
`define SCP_QTR_CYC ((`SCP_BIT_NS / 4 + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_DEB_CYC 2'h2
`define SCP_ID_WAIT 2'h2
`define SCP_PIN_RST 6'h3e
`define SCP_STB_IDLE 1'b0
// ==========================================
// Boot memory access.
`define SCP_EE_ADDR 7'h50
`define SCP_DIR_WR 1'b0
`define SCP_DIR_RD 1'b1
`define SCP_BOOT_WORD 8'h00
// ==========================================
// Register file and index word.
`define SCP_REG_DEPTH 16
`define SCP_REG_LAST 4'hf
`define SCP_CFG_RST 8'h00
`define SCP_IDX_INC 15
`define SCP_IDX_PAIR 14
`define SCP_IDX_AMSB 3
`define SCP_IDX_RST 16'h0000
`define SCP_STEP_ONE 12'h001
`define SCP_STEP_TWO 12'h002
// ==========================================
// Serial frame layout.
`define SCP_LOC_INDEX 3'h0
`define SCP_LOC_DATA 3'h2
`define SCP_HDR_LAST 4'h6
`define SCP_DATA_LAST 4'hf
`define SCP_BIT_ACK 4'h8
`endif

// ---- hw/scp_pkg.sv ----
// ==========================================
// Shared types of the serial configuration ports.
package scp_pkg;
  typedef enum logic [2:0] {
    OP_IDLE = 3'b000, OP_START = 3'b001, OP_WRITE = 3'b010,
    OP_READ = 3'b011, OP_STOP = 3'b100
  } scp_op_t;
  typedef enum logic [3:0] {
    B_INIT = 4'b0000, B_ST1 = 4'b0001, B_DEVW = 4'b0010,
    B_WORD = 4'b0011, B_ST2 = 4'b0100, B_DEVR = 4'b0101,
    B_READ = 4'b0110, B_STOP = 4'b0111, B_DONE = 4'b1000
  } scp_boot_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_HDR = 3'b001, S_WDATA = 3'b010,
    S_TAIL = 3'b011, S_RDATA = 3'b100, S_SKIP = 3'b101
  } scp_ser_t;
endpackage

// ---- hw/scp_link_in.sv ----
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_link_in
  import scp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins: id[5:3], debounce off[2], data[1], strobe[0].
  input wire logic [5:0] pin_raw,
  // Conditioned link events.
  output logic strobe_rise,
  output logic strobe_fall,
  output logic data_level,
  output logic [3:0] ctl_level
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [1:0] deb_cnt_reg;
  logic clean_reg;
  logic rise_reg;
  logic fall_reg;
  // Pins reset to their idle levels; the strobe rests low, so no false edge follows reset.
  localparam logic [5:0] PIN_RST = `SCP_PIN_RST;
  wire strobe_diff = sync_reg[0] != clean_reg;
  // A strobe change is taken once stable, or at once when debounce is off.
  wire deb_ok = sync_reg[2] || deb_cnt_reg == `SCP_DEB_CYC; // [RULE14]

  // ==========================================
  // Two-flop synchronisers, one per pin.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[gi] <= PIN_RST[gi];
          sync_reg[gi] <= PIN_RST[gi];
        end else begin
          meta_reg[gi] <= pin_raw[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  // Strobe debounce and edge pulses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_reg <= 2'h0;
      clean_reg <= `SCP_STB_IDLE;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      rise_reg <= strobe_diff && deb_ok && sync_reg[0];
      fall_reg <= strobe_diff && deb_ok && !sync_reg[0];
      if (!strobe_diff || deb_ok) begin
        deb_cnt_reg <= 2'h0;
      end else begin
        deb_cnt_reg <= deb_cnt_reg + 2'h1;
      end
      if (strobe_diff && deb_ok) begin
        clean_reg <= sync_reg[0]; // [RULE14]
      end
    end
  end

  assign strobe_rise = rise_reg;
  assign strobe_fall = fall_reg;
  assign data_level = sync_reg[1];
  assign ctl_level = sync_reg[5:2];
endmodule

// ---- hw/scp_twi_byte.sv ----
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_twi_byte
  import scp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Operation request.
  input wire logic op_valid,
  input wire scp_op_t op,
  input wire logic [7:0] tx_byte,
  input wire logic tx_nack,
  // Operation result.
  output logic busy,
  output logic done,
  output logic ack_seen,
  output logic [7:0] rx_byte,
  // Open-drain lines, enable high pulls the line low.
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);
  scp_op_t op_reg;
  logic [6:0] tick_cnt_reg;
  logic [1:0] qph_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic nack_reg;
  logic ack_reg;
  logic done_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  // Each bit is four quarter ticks, so the bit rate stays at the limit.
  wire tick = tick_cnt_reg == 7'(`SCP_QTR_CYC - 1); // [RULE2] [RULE27]
  wire byte_op = op_reg == OP_WRITE || op_reg == OP_READ;
  wire ack_slot = bit_reg == `SCP_BIT_ACK;
  wire last_q = tick && qph_reg == 2'h3 && (!byte_op || ack_slot);
  // Level put on SDA while SCL is low; the receiver pulls the ack low.
  wire drive_low = op_reg == OP_STOP || (op_reg == OP_WRITE && !ack_slot && !sh_reg[7]) ||
                   (op_reg == OP_READ && ack_slot && !nack_reg); // [RULE8] [RULE11]

  // Quarter-bit divider, held while idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 7'h00;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= (tick || op_reg == OP_IDLE) ? 7'h00 : tick_cnt_reg + 7'h01;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
    end
  end

  // Bit engine: quarter 0 sets SDA, 1 raises SCL, 2 samples or moves SDA for start and stop, 3 lowers SCL except on a stop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= OP_IDLE;
      qph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      nack_reg <= 1'b0;
      ack_reg <= 1'b0;
      done_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      done_reg <= last_q;
      if (op_reg == OP_IDLE && op_valid) begin
        op_reg <= op;
        sh_reg <= tx_byte;
        nack_reg <= tx_nack;
        qph_reg <= 2'h0;
        bit_reg <= 4'h0;
      end else if (op_reg != OP_IDLE && tick) begin
        qph_reg <= qph_reg + 2'h1;
        unique case (qph_reg)
          2'h0: sda_oe_reg <= drive_low; // [RULE4]
          2'h1: scl_oe_reg <= 1'b0;
          2'h2: begin
            if (op_reg == OP_START) sda_oe_reg <= 1'b1; // [RULE3]
            if (op_reg == OP_STOP) sda_oe_reg <= 1'b0; // [RULE12]
            if (byte_op && ack_slot) ack_reg <= !sda_s_reg;
            if (byte_op && !ack_slot) sh_reg <= {sh_reg[6:0], sda_s_reg};
          end
          2'h3: begin
            scl_oe_reg <= op_reg != OP_STOP;
            bit_reg <= bit_reg + 4'h1;
            if (last_q) op_reg <= OP_IDLE;
          end
        endcase
      end
    end
  end

  assign busy = op_reg != OP_IDLE;
  assign done = done_reg;
  assign ack_seen = ack_reg;
  assign rx_byte = sh_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
endmodule

// ---- verif/scp_ee_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Boot memory on the two-wire bus; pull high drags SDA low.
module scp_ee_model (
  // Bus lines and fault switch.
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  // Drive and counters.
  output logic pull,
  output int n_rd,
  output int n_stop,
  output int per
);
  logic [7:0] sh;
  logic [7:0] b;
  logic rd;
  logic fb;
  logic mack;
  int cnt;
  int idx;
  realtime tr;
  // Byte k of the memory holds a fixed pattern.
  assign b = 8'(idx * 29 + 7);
  initial begin
    pull = 0;
    n_rd = 0;
    n_stop = 0;
  end
  // A start clears the bit count; a stop is counted.
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = -1;
    fb = 1;
    rd = 0;
    idx = 0;
  end
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  // Bits are taken while SCL is high, MSB first; the bit period is timed inside a byte.
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = sda;
    if (cnt > 0 && cnt < 9) per = int'($realtime - tr);
    tr = $realtime;
  end
  // SDA only moves while SCL is low; released after a withheld ack.
  always @(negedge scl) begin
    if (cnt == 7) pull = !rd && !nak && (!fb || sh[7:1] == 7'h50);
    if (cnt == 8 && fb) rd = sh[0];
    if (cnt == 8 && !fb && rd) n_rd++;
    if (cnt == 8 && !fb && rd) idx++;
    if (cnt == 8 && !fb && mack) rd = 0;
    if (cnt == 8) fb = 0;
    cnt = (cnt == 8) ? 0 : cnt + 1;
    if (cnt == 0) pull = 0;
    if (rd && cnt < 8) pull = !b[7 - cnt];
  end
endmodule

// ---- verif/test_scp_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================
// Bench for the serial configuration ports.
module test_scp_top;
  logic clk = 0;
  logic rst_n = 0;
  logic stb = 0;
  logic sin = 0;
  logic dbo = 0;
  logic nak = 1;
  logic pull, scl_oe, sda_oe, sout, b_done, b_err, s_busy, scl_o, sda_o;
  logic [15:0] got;
  int n_errors = 0;
  int samples_checked = 0;
  int n_rd, n_stop, per, s0;
  // Open-drain wires with pull-ups.
  wire logic sda_w = !(sda_oe || pull);
  wire logic scl_w = !scl_oe;
  scp_top u_scp_top (.clk(clk), .rst_n(rst_n), .sda_in(sda_w), .scl_out(scl_o), .scl_oe(scl_oe),
    .sda_out(sda_o), .sda_oe(sda_oe), .serial_strobe_n(stb), .serial_in_line(sin),
    .serial_out_line(sout), .dev_id_strap(3'h5), .debounce_off(dbo), .boot_done(b_done),
    .boot_error(b_err), .serial_busy(s_busy));
  scp_ee_model u_scp_ee_model (.scl(scl_w), .sda(sda_w), .nak(nak), .pull(pull),
    .n_rd(n_rd), .n_stop(n_stop), .per(per));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] eb(input int k);
    return 8'(k * 29 + 7);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobe period: level a at the rise, b at the fall; data bits sample the output before the fall.
  task automatic pulse(input logic a, input logic b);
    sin = a;
    stb = 1;
    tick(4);
    if (a === b) got = {got[14:0], sout};
    sin = b;
    stb = 0;
    tick(4);
  endtask
  // Whole frame; nb below 16 puts an abort after nb data bits, then the frame runs on.
  task automatic frame(input logic [2:0] id, input logic [2:0] loc, input logic rd,
    input logic [15:0] d, input int nb);
    logic [6:0] h;
    h = {id, loc, rd};
    pulse(1, 0);
    for (int i = 6; i >= 0; i--) pulse(h[i], h[i]);
    for (int i = 15; i >= 0; i--) begin
      if (i == 15 - nb) pulse(0, 1);
      pulse(rd | d[i], rd | d[i]);
    end
    if (!rd) pulse(1, 1);
    if (!rd) pulse(1, 1);
    tick(8);
  endtask
  task automatic rst_wait(input int n);
    rst_n = 0;
    tick(2);
    rst_n = 1;
    for (int i = 0; i < n && b_done !== 1'b1; i++) tick(1);
  endtask
  // The memory refuses its address: the master stops and flags it.
  task automatic t_nak;
    rst_wait(20000);
    `CHK(b_err, 1'b1)
    `CHK(n_stop > 0, 1'b1)
    `CHK(sda_w & scl_w, 1'b1)
  endtask
  // Full boot read of sixteen bytes at the nominal bit period.
  task automatic t_boot;
    nak = 0;
    s0 = n_stop;
    rst_wait(110000);
    `CHK(b_err, 1'b0)
    `CHK(n_rd, 16)
    `CHK(n_stop - s0, 1)
    `CHK(per, 20000)
    `CHK(b_done, 1'b1)
    `CHK({scl_o, sda_o}, 2'h0)
    `CHK(sda_w & scl_w, 1'b1)
  endtask
  // Auto-stepping paired reads return every boot byte; an abort inside one read is ignored.
  task automatic t_rd_all;
    frame(5, 0, 0, 16'hC000, 16);
    for (int k = 0; k < 16; k += 2) begin
      frame(5, 2, 1, 16'h0000, k == 4 ? 8 : 16);
      `CHK(got, {eb(k + 1), eb(k)})
    end
  endtask
  // Paired write and read back; the index reads back as written.
  task automatic t_pair;
    frame(5, 0, 0, 16'h4004, 16);
    frame(5, 0, 1, 16'h0000, 16);
    `CHK(got, 16'h4004)
    frame(5, 2, 0, 16'hBEEF, 16);
    frame(5, 2, 1, 16'h0000, 16);
    `CHK(got, 16'hBEEF)
  endtask
  // Plain write keeps only the low byte; a foreign id and an abort change nothing.
  task automatic t_single;
    frame(5, 0, 0, 16'h0006, 16);
    frame(5, 2, 0, 16'h3412, 16);
    frame(4, 2, 0, 16'h0077, 16);
    frame(5, 2, 0, 16'h0099, 12);
    dbo = 1;
    frame(5, 2, 1, 16'h0000, 16);
    `CHK(got, {eb(7), 8'h12})
    `CHK(s_busy, 1'b0)
  endtask
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog over the expected run length.
  initial begin
    #5_000_000;
    n_errors++;
    print_verdict();
  end
  initial begin
    t_nak();
    t_boot();
    t_rd_all();
    t_pair();
    t_single();
    print_verdict();
  end
endmodule
